// ---- supervisor_reset_watchdog.sv ----
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
module supervisor_reset_watchdog
    import supv_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    // Avalon-MM slave
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // Monitor comparator, high while below trip level
    input  wire logic        i_below_trip,
    // Watchdog pins
    input  wire logic        i_watchdog_service_in,
    output logic             o_watchdog_service_out,
    output logic             o_watchdog_service_oe_n,
    input  wire logic        i_watchdog_range_sel,
    // Reset outputs
    output logic             o_rst_n,
    output logic             o_rst,
    input  wire logic        i_rst_line,
    output logic             o_rst_line_out,
    output logic             o_rst_line_oe_n
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        sup_state_t  state;
        logic [6:0]  pre;
        logic [19:0] rp_cnt;
        logic [31:0] wd_cnt;
        logic [2:0]  uv_s;
        logic        uv_f;
        logic [2:0]  svc_s;
        logic        svc_f;
        logic [2:0]  rng_s;
        logic        rng_f;
        logic [2:0]  line_s;
        logic        line_f;
        logic [3:0]  pulse;
        logic        wd_en;
        logic [19:0] rp_len;
        logic [19:0] wd_base;
        logic        cause_wd;
        logic        rst_act;
        logic        rst_n;
        logic        svc_out;
        logic        svc_oe_n;
        logic        wait_rq;
        logic [31:0] rdata;
    } st_t;

    st_t st;
    st_t next_st;

    logic        tick;
    logic        uv_change;
    logic        svc_edge;
    logic        rng_edge;
    logic        line_change;
    logic [31:0] period;
    logic [19:0] rp_eff;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Active watchdog period in ticks
    function automatic logic [31:0] wd_period(input logic [19:0] base,
                                              input logic ext);
        logic [31:0] b;
        b = {12'h000, base};
        return ext ? b * EXT_MULT : b;
    endfunction

    // Point at which the own service pulse fires
    function automatic logic [31:0] svc_point(input logic [31:0] p);
        logic [39:0] w;
        w = {8'h00, p};
        return 32'((w * SVC_PCT) / PCT_FULL);
    endfunction

    // Byte-lane merge for partial writes
    function automatic logic [19:0] merge20(input logic [19:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        logic [31:0] r;
        r = {12'h000, old};
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r[19:0];
    endfunction

    // A change counts once the second and third stages agree
    function automatic logic sync_change(input logic [2:0] s,
                                         input logic f);
        return (s[1] == s[2]) && (s[2] != f);
    endfunction

    // ----------------------------------------------------------------
    // Derived terms
    // ----------------------------------------------------------------
    // Free-running microsecond tick and input events
    assign tick        = (st.pre == TICK_LAST);
    assign uv_change   = sync_change(st.uv_s, st.uv_f);
    assign svc_edge    = sync_change(st.svc_s, st.svc_f);
    assign rng_edge    = sync_change(st.rng_s, st.rng_f);
    assign line_change = sync_change(st.line_s, st.line_f);
    assign period      = wd_period(st.wd_base, st.rng_f);
    // Zero length would skip the pulse, so one tick is the floor
    assign rp_eff      = (st.rp_len == 20'h0_0000) ? 20'h0_0001 : st.rp_len;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic uv_now;
        logic wd_clear;
        logic [4:0] a;
        uv_now   = 1'b0;
        wd_clear = 1'b0;
        a        = i_avs_address;
        next_st  = st;

        // Time base prescaler
        next_st.pre = tick ? 7'h00 : st.pre + 7'h01;

        // Three-stage synchronisers; stage 1 feeds stage 2 only
        next_st.uv_s   = {st.uv_s[1:0], i_below_trip};
        next_st.svc_s  = {st.svc_s[1:0], i_watchdog_service_in};
        next_st.rng_s  = {st.rng_s[1:0], i_watchdog_range_sel};
        next_st.line_s = {st.line_s[1:0], i_rst_line};
        if (uv_change) begin
            next_st.uv_f = st.uv_s[2];
        end
        if (svc_edge) begin
            next_st.svc_f = st.svc_s[2];
        end
        if (rng_edge) begin
            next_st.rng_f = st.rng_s[2];
        end
        if (line_change) begin
            next_st.line_f = st.line_s[2];
        end
        uv_now = uv_change ? st.uv_s[2] : st.uv_f;

        // Either service edge or a range change clears the count
        wd_clear = svc_edge || rng_edge;

        // Supervisor sequence
        case (st.state)
            S_UNDER: begin
                next_st.rp_cnt = 20'h0_0000;
                if (!uv_now) begin
                    next_st.state = S_PULSE;
                end
            end
            S_PULSE: begin
                if (uv_now) begin
                    next_st.state  = S_UNDER;
                    next_st.rp_cnt = 20'h0_0000;
                end else if (tick) begin
                    if (st.rp_cnt + 20'h0_0001 >= rp_eff) begin
                        next_st.state = S_RUN;
                    end else begin
                        next_st.rp_cnt = st.rp_cnt + 20'h0_0001;
                    end
                end
            end
            S_RUN: begin
                if (uv_now) begin
                    next_st.state    = S_UNDER;
                    next_st.cause_wd = 1'b0;
                end else if (wd_clear) begin
                    next_st.wd_cnt = 32'h0000_0000;
                end else if (st.wd_en && tick) begin
                    if (st.wd_cnt + 32'h0000_0001 >= period) begin
                        next_st.state    = S_PULSE;
                        next_st.cause_wd = 1'b1;
                    end else begin
                        next_st.wd_cnt = st.wd_cnt + 32'h0000_0001;
                    end
                end
            end
            default: begin
                next_st.state = S_UNDER;
            end
        endcase

        // Counter held clear while reset is active
        if (next_st.state != S_RUN) begin
            next_st.wd_cnt = 32'h0000_0000;
        end
        if (next_st.state == S_RUN) begin
            next_st.rp_cnt = 20'h0_0000;
        end
        next_st.rst_act = (next_st.state != S_RUN);
        next_st.rst_n   = (next_st.state == S_RUN);

        // Own drive of the service line in extended range
        if (st.pulse != 4'h0) begin
            next_st.pulse = st.pulse - 4'h1;
        end else if (st.rng_f && st.wd_en && st.state == S_RUN && tick
                     && st.wd_cnt == svc_point(period)) begin
            next_st.pulse = SVC_PULSE_CYC;
        end
        next_st.svc_oe_n = !(next_st.rng_f && next_st.wd_en);
        next_st.svc_out  = (next_st.pulse != 4'h0);

        // Bus: one wait cycle, then answer
        if (st.wait_rq) begin
            if (i_avs_read || i_avs_write) begin
                next_st.wait_rq = 1'b0;
                if (a == ADDR_CTRL) begin
                    next_st.rdata = {31'h0, st.wd_en};
                end else if (a == ADDR_RP_LEN) begin
                    next_st.rdata = {12'h000, st.rp_len};
                end else if (a == ADDR_WD_BASE) begin
                    next_st.rdata = {12'h000, st.wd_base};
                end else if (a == ADDR_STATUS) begin
                    next_st.rdata = {27'h0, !st.line_f, st.cause_wd,
                                     st.rng_f, st.uv_f, st.rst_act};
                end else if (a == ADDR_WD_CNT) begin
                    next_st.rdata = st.wd_cnt;
                end else begin
                    next_st.rdata = 32'h0000_0000;
                end
            end
        end else begin
            next_st.wait_rq = 1'b1;
            if (i_avs_write) begin
                if (a == ADDR_CTRL && i_avs_byteenable[0]) begin
                    next_st.wd_en = i_avs_writedata[CTRL_WD_EN];
                end else if (a == ADDR_RP_LEN) begin
                    next_st.rp_len = merge20(st.rp_len, i_avs_writedata,
                                             i_avs_byteenable);
                end else if (a == ADDR_WD_BASE) begin
                    next_st.wd_base = merge20(st.wd_base, i_avs_writedata,
                                              i_avs_byteenable);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Synchronous reset; the enable freezes everything else
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st          <= '0;
            st.state    <= S_UNDER;
            st.uv_f     <= 1'b1;
            st.line_f   <= 1'b1;
            // Sync stages start at the filtered levels, so no false edge follows reset
            st.uv_s     <= 3'b111;
            st.line_s   <= 3'b111;
            st.wd_en    <= WD_EN_RST;
            st.rp_len   <= RP_LEN_RST;
            st.wd_base  <= WD_BASE_RST;
            st.rst_act  <= 1'b1;
            st.svc_oe_n <= 1'b1;
            st.wait_rq  <= 1'b1;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flops or constant
    // ----------------------------------------------------------------
    assign o_rst_n                 = st.rst_n;
    assign o_rst                   = st.rst_act;
    assign o_rst_line_out          = 1'b0;
    assign o_rst_line_oe_n         = st.rst_n;
    assign o_watchdog_service_out  = st.svc_out;
    assign o_watchdog_service_oe_n = st.svc_oe_n;
    assign o_avs_readdata          = st.rdata;
    assign o_avs_waitrequest       = st.wait_rq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    rst_inverse_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rst == !o_rst_n && o_rst_line_oe_n == o_rst_n)
        else $error("reset outputs disagree");

    uv_asserts_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && uv_change && st.uv_s[2]) |=> (st.rst_act && st.state == S_UNDER))
        else $error("under-voltage did not assert reset");

    wd_held_a: assert property (@(posedge i_clk) disable iff (i_rst)
        st.rst_act |-> (st.wd_cnt == 32'h0000_0000))
        else $error("watchdog counter moved during reset");

    restart_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(st.rst_act) |-> (st.wd_cnt == 32'h0000_0000 && $past(st.state) == S_PULSE))
        else $error("watchdog did not restart from zero");

    pulse_length_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(st.rst_act) |-> ($past(st.rp_cnt) + 20'h0_0001 >= $past(rp_eff)))
        else $error("reset released before pulse length");

    svc_clears_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && svc_edge && st.state == S_RUN && !uv_change)
        |=> (st.wd_cnt == 32'h0000_0000))
        else $error("service edge did not clear counter");

    range_clears_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && rng_edge && st.state == S_RUN && !uv_change)
        |=> (st.wd_cnt == 32'h0000_0000 && st.rng_f == $past(st.rng_s[2])))
        else $error("range change did not clear counter");

    normal_no_drive_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !st.rng_f |-> st.svc_oe_n)
        else $error("service line driven in normal range");

    wd_disabled_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ce && !st.wd_en && st.state == S_RUN && !uv_change)
        |=> (st.state == S_RUN))
        else $error("disabled watchdog fired");

    powerup_held_a: assert property (@(posedge i_clk)
        $past(i_rst) |-> (st.rst_act && st.state == S_UNDER))
        else $error("reset not held after power-up");

    // Pulse timer idle until recovery; own pulse only at its point
    timer_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (st.state == S_UNDER) |-> (st.rp_cnt == 20'h0_0000 && st.rst_act))
        else $error("pulse timer ran before recovery");

    own_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(st.svc_out)
        |-> ($past(st.rng_f) && $past(st.wd_cnt) == svc_point($past(period))))
        else $error("own service pulse off its point");

endmodule // supervisor_reset_watchdog

// ---- supervisor_reset_watchdog_test.sv ----
`timescale 1ns/10ps
module supervisor_reset_watchdog_test
    import supv_pkg::*;
;
    typedef struct { logic [4:0] addr; logic [31:0] exp; } row_t;

    logic        clk = 1'b0;
    logic        rst, ce, avs_read, avs_write, below_trip;
    logic [4:0]  avs_address;
    logic [3:0]  be;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic        avs_waitrequest, svc_out, svc_oe_n, svc_line, range_sel;
    logic        rst_n, rst_o, rst_line, rst_line_out, rst_line_oe_n;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          n;
    row_t        rows [5];

    always #5 clk = ~clk;

    supervisor_reset_watchdog i_dut (
        .i_clk(clk), .i_rst(rst), .i_ce(ce),
        .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
        .i_avs_writedata(avs_writedata), .i_avs_byteenable(be),
        .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
        .i_below_trip(below_trip), .i_watchdog_service_in(svc_line),
        .o_watchdog_service_out(svc_out), .o_watchdog_service_oe_n(svc_oe_n),
        .i_watchdog_range_sel(range_sel), .o_rst_n(rst_n), .o_rst(rst_o),
        .i_rst_line(rst_line), .o_rst_line_out(rst_line_out),
        .o_rst_line_oe_n(rst_line_oe_n)
    );

    supv_cpu_model i_cpu (
        .i_clk(clk), .i_svc_out(svc_out), .i_svc_oe_n(svc_oe_n),
        .i_rst_line_out(rst_line_out), .i_rst_line_oe_n(rst_line_oe_n),
        .o_svc_line(svc_line), .o_range_sel(range_sel), .o_rst_line(rst_line)
    );

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] in_rng(input int v, input int lo, input int hi);
        return {31'h0000_0000, (v >= lo && v <= hi)};
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Run needs about 60k cycles; cut a hang well after that
    initial begin
        #1_000_000;
        mismatches++;
        wrap_up();
    end

    // Both reset polarities watched on every cycle outside reset
    always @(posedge clk) begin
        if (!rst) begin
            check("reset polarity pair", {31'h0000_0000, rst_o}, {31'h0000_0000, ~rst_n});
        end
    end

    // ------------------------------------------------------------
    // Bus master and waits, entered just after a rising edge
    // ------------------------------------------------------------
    task automatic bus_rd(input logic [4:0] a, output logic [31:0] rd);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic bus_wr(input logic [4:0] a, input logic [31:0] wd);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_write     <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    // Cycles until reset reaches a level; returns lim when it never does
    task automatic wait_rst(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (cnt < lim && rst_o !== lvl) begin
            @(posedge clk);
            cnt++;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst <= 1'b1;
        ce <= 1'b1;
        be <= 4'hF;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= 5'h00;
        avs_writedata <= 32'h0000_0000;
        below_trip <= 1'b1;
        rows[0] = '{ADDR_CTRL, {31'h0000_0000, WD_EN_RST}};
        rows[1] = '{ADDR_RP_LEN, {12'h000, RP_LEN_RST}};
        rows[2] = '{ADDR_WD_BASE, {12'h000, WD_BASE_RST}};
        rows[3] = '{ADDR_STATUS, 32'h0000_0013};
        rows[4] = '{5'h14, 32'h0000_0000};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            bus_rd(rows[i].addr, d);
            check("register reset value", d, rows[i].exp);
        end
        $display("test register table done");

        // Short counts: 3 tick pulse, 5 tick period
        // Low lane only: upper bytes must be kept
        be <= 4'h1;
        bus_wr(ADDR_RP_LEN, 32'hFFFF_FF03);
        be <= 4'hF;
        bus_wr(ADDR_WD_BASE, 32'h0000_0005);
        check("held before recovery", {31'h0000_0000, rst_o}, 32'h0000_0001);
        below_trip <= 1'b0;
        wait_rst(1'b0, 400, n);
        check("recovery pulse", in_rng(n, 195, 320), 32'h0000_0001);
        $display("test power-up recovery done");

        // Single edges 400 cycles apart keep a 500 cycle period alive
        for (int i = 0; i < 8; i++) begin
            i_cpu.drive_svc(i[0] ? 1'b0 : 1'b1);
            repeat (400) @(posedge clk);
        end
        bus_rd(ADDR_STATUS, d);
        check("serviced, no watchdog reset", {31'h0000_0000, d[3]}, 32'h0000_0000);
        $display("test servicing done");

        // Silence: expiry, cleared counter, fixed pulse, repeat
        wait_rst(1'b1, 400, n);
        check("expiry reached", in_rng(n, 0, 399), 32'h0000_0001);
        bus_rd(ADDR_WD_CNT, d);
        check("counter held in reset", d, 32'h0000_0000);
        wait_rst(1'b0, 400, n);
        check("watchdog pulse length", in_rng(n, 190, 310), 32'h0000_0001);
        wait_rst(1'b1, 700, n);
        check("restart from zero", in_rng(n, 400, 610), 32'h0000_0001);
        bus_rd(ADDR_STATUS, d);
        check("cause is watchdog", {31'h0000_0000, d[3]}, 32'h0000_0001);
        wait_rst(1'b0, 400, n);
        $display("test watchdog expiry done");

        // Range select blip late in the period restarts the count
        repeat (350) @(posedge clk);
        i_cpu.set_range(1'b1);
        repeat (10) @(posedge clk);
        i_cpu.set_range(1'b0);
        wait_rst(1'b1, 700, n);
        check("range change clears", in_rng(n, 440, 620), 32'h0000_0001);
        wait_rst(1'b0, 400, n);
        $display("test range clear done");

        // Brief drop of the monitored input
        below_trip <= 1'b1;
        wait_rst(1'b1, 10, n);
        check("assert on drop", in_rng(n, 0, 6), 32'h0000_0001);
        repeat (20) @(posedge clk);
        check("held while low", {31'h0000_0000, rst_o}, 32'h0000_0001);
        below_trip <= 1'b0;
        wait_rst(1'b0, 400, n);
        check("debounce pulse", in_rng(n, 195, 320), 32'h0000_0001);
        $display("test brown-out done");

        // Enable low freezes the time base, so no expiry
        ce <= 1'b0;
        wait_rst(1'b1, 1000, n);
        check("frozen by enable", n, 32'h0000_03E8);
        ce <= 1'b1;
        $display("test clock enable done");

        // Watchdog off, then processor pulls the shared line
        bus_wr(ADDR_CTRL, 32'h0000_0000);
        wait_rst(1'b1, 1500, n);
        check("disabled watchdog", n, 32'h0000_05DC);
        i_cpu.pull_rst(1'b1);
        repeat (6) @(posedge clk);
        bus_rd(ADDR_STATUS, d);
        check("shared line seen low", {31'h0000_0000, d[4]}, 32'h0000_0001);
        check("own drive released", {31'h0000_0000, rst_line_oe_n}, 32'h0000_0001);
        i_cpu.pull_rst(1'b0);
        $display("test disable and shared line done");

        // Extended range, line floating: own pulse near 94 percent
        i_cpu.set_range(1'b1);
        i_cpu.float_svc();
        bus_wr(ADDR_WD_BASE, 32'h0000_0001);
        bus_wr(ADDR_CTRL, 32'h0000_0001);
        n = 0;
        while (n < 50000 && svc_out !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        check("own pulse time", in_rng(n, 46600, 47300), 32'h0000_0001);
        check("device drives line", {31'h0000_0000, svc_oe_n}, 32'h0000_0000);
        check("no reset in extended", {31'h0000_0000, rst_o}, 32'h0000_0000);
        repeat (20) @(posedge clk);
        bus_rd(ADDR_WD_CNT, d);
        check("own pulse clears counter", in_rng(int'(d), 0, 2), 32'h0000_0001);
        $display("test extended range done");

        // Mid-run reset holds reset and restores defaults
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        check("reset held in reset", {31'h0000_0000, rst_o}, 32'h0000_0001);
        check("no own drive in reset", {31'h0000_0000, svc_oe_n}, 32'h0000_0001);
        rst <= 1'b0;
        @(posedge clk);
        bus_rd(ADDR_RP_LEN, d);
        check("pulse length after reset", d, {12'h000, RP_LEN_RST});
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule // supervisor_reset_watchdog_test

// ---- supv_cpu_model.sv ----
`timescale 1ns/10ps
module supv_cpu_model (
    // Clock
    input  wire logic i_clk,
    // Device drive of the shared pins
    input  wire logic i_svc_out,
    input  wire logic i_svc_oe_n,
    input  wire logic i_rst_line_out,
    input  wire logic i_rst_line_oe_n,
    // Resolved pin levels
    output logic      o_svc_line,
    output logic      o_range_sel,
    output logic      o_rst_line
);
    logic svc_drive = 1'b1;
    logic svc_val   = 1'b0;
    logic rst_pull  = 1'b0;
    logic float_lvl = 1'b0;

    initial o_range_sel = 1'b0;

    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // Undriven line wanders, so a stale level never passes for a drive
    always_ff @(posedge i_clk) begin
        float_lvl <= ~float_lvl;
    end

    // Processor drive wins, then the device buffer, else floating
    always_comb begin
        if (svc_drive) begin
            o_svc_line = svc_val;
        end else if (!i_svc_oe_n) begin
            o_svc_line = i_svc_out;
        end else begin
            o_svc_line = float_lvl;
        end
    end

    // One pull-up: either party may pull the shared reset line low
    assign o_rst_line = (rst_pull || (!i_rst_line_oe_n && !i_rst_line_out)) ? 1'b0 : 1'b1;

    // ------------------------------------------------------------
    // Processor actions, called just after a rising edge
    // ------------------------------------------------------------
    // Level held for microseconds, far above the 30 ns minimum
    task automatic drive_svc(input logic v);
        svc_drive <= 1'b1;
        svc_val   <= v;
    endtask

    // Only legal in extended range
    task automatic float_svc();
        svc_drive <= 1'b0;
    endtask

    // Extended before sleep, normal while working
    task automatic set_range(input logic v);
        o_range_sel <= v;
    endtask

    task automatic pull_rst(input logic v);
        rst_pull <= v;
    endtask
endmodule // supv_cpu_model

// ---- supv_pkg.sv ----
package supv_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [4:0]  ADDR_CTRL    = 5'h00;
    localparam logic [4:0]  ADDR_RP_LEN  = 5'h04;
    localparam logic [4:0]  ADDR_WD_BASE = 5'h08;
    localparam logic [4:0]  ADDR_STATUS  = 5'h0C;
    localparam logic [4:0]  ADDR_WD_CNT  = 5'h10;

    // Field positions
    localparam int CTRL_WD_EN    = 0;
    localparam int STAT_RST      = 0;
    localparam int STAT_UV       = 1;
    localparam int STAT_EXT      = 2;
    localparam int STAT_CAUSE_WD = 3;
    localparam int STAT_LINE_LO  = 4;

    // Reset values
    localparam logic        WD_EN_RST   = 1'b1;
    localparam logic [19:0] RP_LEN_RST  = 20'h0_00C8;
    localparam logic [19:0] WD_BASE_RST = 20'h0_03E8;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          TICK_NS       = 1000;
    localparam int          TICK_CYC_I    = TICK_NS / CLK_PERIOD_NS;
    localparam logic [6:0]  TICK_LAST     = 7'(TICK_CYC_I - 1);
    localparam int          SVC_PULSE_NS  = 80;
    localparam int          SVC_PULSE_I   = (SVC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  SVC_PULSE_CYC = 4'(SVC_PULSE_I);
    localparam logic [31:0] EXT_MULT      = 32'h0000_01F4;
    localparam logic [39:0] SVC_PCT       = 40'h00_0000_005E;
    localparam logic [39:0] PCT_FULL      = 40'h00_0000_0064;

    // Supervisor states, Gray along under -> pulse -> run
    typedef enum logic [1:0] {
        S_UNDER = 2'b00,
        S_PULSE = 2'b01,
        S_RUN   = 2'b11
    } sup_state_t;
endpackage
